// >>> rtl/io_pin_function_regs.svh
`ifndef IO_PIN_FUNCTION_REGS_SVH
`define IO_PIN_FUNCTION_REGS_SVH

// register offsets (word index on the plain register port)
`define OFS_ANA_E 8'h00
`define OFS_ANA_F 8'h01
`define OFS_ANA_G 8'h02
`define OFS_CN_EN 8'h10
`define OFS_CN_PU 8'h18
`define OFS_CN_PD 8'h20
`define OFS_CN_STAT 8'h28
`define OFS_LOCK 8'h30
`define OFS_KEY 8'h31
`define OFS_LEVEL 8'h38
`define OFS_IN_MAP 8'h40
`define OFS_OUT_MAP 8'h60

// register counts
`define CN_WORDS 6
`define LEVEL_WORDS 3
`define IN_MAP_WORDS 18
`define OUT_MAP_WORDS 16

// implemented bits and reset values of the analog selects
`define ANA_E_MASK 16'h0200
`define ANA_F_MASK 16'h0001
`define ANA_G_MASK 16'h03C0
`define ANA_E_RST 16'h0200
`define ANA_F_RST 16'h0001
`define ANA_G_RST 16'h03C0

// field positions
`define ANA_E_BIT 9
`define ANA_F_BIT 0
`define ANA_G_LSB 6
`define MAP_LO_LSB 0
`define MAP_HI_LSB 8
`define CN_FLAG_BIT 0
`define LOCK_BIT 0

// remappable pin behind each analog-capable port pin
`define RP_OF_E9 6'h18
`define RP_OF_F0 6'h10
`define RP_OF_G6 6'h13
`define RP_OF_G7 6'h15
`define RP_OF_G8 6'h1A
`define RP_OF_G9 6'h1B

// sizes
`define NUM_CN 84
`define NUM_RP 44
`define NUM_RP_OUT 32
`define NUM_PERIPH_IN 36
`define NUM_PERIPH_OUT 30

// map reset values and unlock keys
`define IN_MAP_RST 6'h3F
`define OUT_MAP_RST 6'h00
`define UNLOCK_KEY1 16'h0046
`define UNLOCK_KEY2 16'h0057

// cycles of input settling ignored after reset
`define CN_PRIME_CYCLES 2'h3

`endif

// >>> rtl/io_pin_function_pkg.sv
`default_nettype none
package io_pin_function_pkg;
	typedef logic [15:0] word_t;
	typedef logic [7:0] addr_t;
	typedef logic [5:0] mapSel_t;
	typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_ARMED} unlock_t;
endpackage
`default_nettype wire

// >>> rtl/pin_sync.sv
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// levels
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			syncOut <= '0;
		end else begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/io_pin_function_control.sv
// Contract
// - analog select one: pin analog, digital port read blocked
// - analog select zero: pin digital, level readable through port
// - unimplemented register bits ignore writes and read zero, except notice bits 84-95, which are stored and read back
// - enabled change-notice pin changing state raises interrupt request
// - change detection works without a running clock
// - one interrupt-enable bit per each of 84 change-notice inputs
// - separate weak pull-up and pull-down enable per notice pin
// - 44 remap pins; 0-31 in and out, 32-43 input only
// - input and output maps configured independently onto any pin
// - hardware safeguard prevents spurious changes to pin mapping
// - remapped peripherals unconnected until assigned; fixed ones default
// - no remapping for i2c, notice, alarm, parallel, graphics, analog
// - remapped output beats port output and parallel port on pin
// - fixed usb outputs beat remapped outputs on same pin
// - remapped inputs never own pin; direction or fixed owner does
// - remapped input gated off while pin analog, normal when digital
// - six-bit field per peripheral input selects source pin
// - output selection all zeros leaves pin unconnected
`include "io_pin_function_regs.svh"
`default_nettype none
module io_pin_function_control (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire io_pin_function_pkg::addr_t regAddr,
	input wire io_pin_function_pkg::word_t regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output io_pin_function_pkg::word_t regRdData,
	// change notification pins
	input wire logic [`NUM_CN-1:0] cnIn,
	output logic [`NUM_CN-1:0] pullUpEn,
	output logic [`NUM_CN-1:0] pullDnEn,
	output logic cnIrq,
	output logic cnWake,
	// remappable pins
	input wire logic [`NUM_RP-1:0] pinIn,
	output logic [`NUM_RP_OUT-1:0] pinOut,
	output logic [`NUM_RP_OUT-1:0] pinOe,
	output logic [`NUM_RP-1:0] portInLvl,
	// port and fixed-function owners of the output pins
	input wire logic [`NUM_RP_OUT-1:0] portOut,
	input wire logic [`NUM_RP_OUT-1:0] portDirIn,
	input wire logic [`NUM_RP_OUT-1:0] usbOwn,
	input wire logic [`NUM_RP_OUT-1:0] usbOutLvl,
	input wire logic [`NUM_RP_OUT-1:0] usbOe,
	// remappable peripherals
	input wire logic [`NUM_PERIPH_OUT:1] periphOut,
	output logic [`NUM_PERIPH_IN-1:0] periphIn
);
	import io_pin_function_pkg::*;

	function automatic logic hit(input addr_t a, input addr_t base,
		input addr_t n);
		hit = (a >= base) && (a < base + n);
	endfunction

	word_t anaE_r, anaF_r, anaG_r;
	word_t cnEn_r [`CN_WORDS];
	word_t cnPu_r [`CN_WORDS];
	word_t cnPd_r [`CN_WORDS];
	mapSel_t inSel_r [`NUM_PERIPH_IN];
	mapSel_t outSel_r [`NUM_RP_OUT];
	logic cnFlag_r, locked_r;
	unlock_t unlock_r;
	logic [1:0] prime_r;
	logic [`NUM_CN-1:0] cnSync, cnPrev_r, cnEnVec;
	logic [`NUM_RP-1:0] pinSync, analogPin, gatedLvl;
	logic [16*`LEVEL_WORDS-1:0] lvlWords;
	logic cnChange;
	word_t rdNxt;
	logic [2:0] cnIdx;
	logic [4:0] inIdx;
	logic [3:0] outIdx;
	logic mapWrOk;

	assign cnIdx = regAddr[2:0];
	assign inIdx = regAddr[4:0];
	assign outIdx = regAddr[3:0];
	// map writes only land while unlocked
	assign mapWrOk = regWr && !locked_r;

	pin_sync #(.W(`NUM_CN)) cnSyncU (
		.clk(clk),
		.rstn(rstn),
		.asyncIn(cnIn),
		.syncOut(cnSync)
	);
	pin_sync #(.W(`NUM_RP)) rpSyncU (
		.clk(clk),
		.rstn(rstn),
		.asyncIn(pinIn),
		.syncOut(pinSync)
	);

	// analog-capable pins and their select bits
	always_comb begin
		analogPin = '0;
		analogPin[`RP_OF_E9] = anaE_r[`ANA_E_BIT];
		analogPin[`RP_OF_F0] = anaF_r[`ANA_F_BIT];
		analogPin[`RP_OF_G6] = anaG_r[`ANA_G_LSB];
		analogPin[`RP_OF_G7] = anaG_r[`ANA_G_LSB+1];
		analogPin[`RP_OF_G8] = anaG_r[`ANA_G_LSB+2];
		analogPin[`RP_OF_G9] = anaG_r[`ANA_G_LSB+3];
	end
	assign gatedLvl = pinSync & ~analogPin;

	// analog selects, only implemented bits are stored
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			anaE_r <= `ANA_E_RST;
			anaF_r <= `ANA_F_RST;
			anaG_r <= `ANA_G_RST;
		end else if (regWr) begin
			if (regAddr == `OFS_ANA_E)
				anaE_r <= regWrData & `ANA_E_MASK;
			if (regAddr == `OFS_ANA_F)
				anaF_r <= regWrData & `ANA_F_MASK;
			if (regAddr == `OFS_ANA_G)
				anaG_r <= regWrData & `ANA_G_MASK;
		end
	end

	// change-notice enables and weak pulls
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `CN_WORDS; i++) begin
				cnEn_r[i] <= '0;
				cnPu_r[i] <= '0;
				cnPd_r[i] <= '0;
			end
		end else if (regWr && cnIdx < 3'(`CN_WORDS)) begin
			if (hit(regAddr, `OFS_CN_EN, 8'(`CN_WORDS)))
				cnEn_r[cnIdx] <= regWrData;
			if (hit(regAddr, `OFS_CN_PU, 8'(`CN_WORDS)))
				cnPu_r[cnIdx] <= regWrData;
			if (hit(regAddr, `OFS_CN_PD, 8'(`CN_WORDS)))
				cnPd_r[cnIdx] <= regWrData;
		end
	end

	genvar g;
	generate
		for (g = 0; g < `NUM_CN; g++) begin : gCn
			assign cnEnVec[g] = cnEn_r[g/16][g%16];
			assign pullUpEn[g] = cnPu_r[g/16][g%16];
			assign pullDnEn[g] = cnPd_r[g/16][g%16];
		end
	endgenerate

	// the sync chain holds reset zeros for a while; ignore that settling
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prime_r <= '0;
			cnPrev_r <= '0;
		end else begin
			if (prime_r != `CN_PRIME_CYCLES)
				prime_r <= prime_r + 2'h1;
			cnPrev_r <= cnSync;
		end
	end
	assign cnChange = (prime_r == `CN_PRIME_CYCLES) &&
		(|((cnSync ^ cnPrev_r) & cnEnVec));

	// raw pin against last sampled level; no clock needed to see a change,
	// so this level can wake the clock tree from sleep
	assign cnWake = (prime_r == `CN_PRIME_CYCLES) &&
		(|((cnIn ^ cnPrev_r) & cnEnVec));

	// sticky flag, write one clears; a new change in that cycle wins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cnFlag_r <= 1'b0;
		else if (cnChange)
			cnFlag_r <= 1'b1;
		else if (regWr && regAddr == `OFS_CN_STAT &&
			regWrData[`CN_FLAG_BIT])
			cnFlag_r <= 1'b0;
	end
	assign cnIrq = cnFlag_r;

	// lock: set by a plain write, cleared only after the two-key sequence
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			locked_r <= 1'b0;
			unlock_r <= UNL_IDLE;
		end else if (regWr) begin
			unlock_r <= UNL_IDLE;
			case (unlock_r)
				UNL_IDLE: begin
					if (regAddr == `OFS_KEY && regWrData == `UNLOCK_KEY1)
						unlock_r <= UNL_KEY1;
				end
				UNL_KEY1: begin
					if (regAddr == `OFS_KEY && regWrData == `UNLOCK_KEY2)
						unlock_r <= UNL_ARMED;
				end
				UNL_ARMED: begin
					if (regAddr == `OFS_LOCK && !regWrData[`LOCK_BIT])
						locked_r <= 1'b0;
				end
				default: unlock_r <= UNL_IDLE;
			endcase
			if (regAddr == `OFS_LOCK && regWrData[`LOCK_BIT])
				locked_r <= 1'b1;
		end
	end

	// input maps per peripheral and output maps per pin, kept apart
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `NUM_PERIPH_IN; i++)
				inSel_r[i] <= `IN_MAP_RST;
			for (int i = 0; i < `NUM_RP_OUT; i++)
				outSel_r[i] <= `OUT_MAP_RST;
		end else if (mapWrOk) begin
			if (hit(regAddr, `OFS_IN_MAP, 8'(`IN_MAP_WORDS))) begin
				inSel_r[{inIdx, 1'b0}] <= regWrData[5:0];
				inSel_r[{inIdx, 1'b1}] <= regWrData[13:8];
			end
			if (hit(regAddr, `OFS_OUT_MAP, 8'(`OUT_MAP_WORDS))) begin
				outSel_r[{outIdx, 1'b0}] <= regWrData[5:0];
				outSel_r[{outIdx, 1'b1}] <= regWrData[13:8];
			end
		end
	end

	// i2c, notice, alarm, parallel and graphics signals never pass here
	generate
		for (g = 0; g < `NUM_PERIPH_IN; g++) begin : gIn
			// out-of-range selects (reset value) leave the input at zero
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn)
					periphIn[g] <= 1'b0;
				else if (inSel_r[g] < 6'(`NUM_RP))
					periphIn[g] <= gatedLvl[inSel_r[g]];
				else
					periphIn[g] <= 1'b0;
			end
		end
		for (g = 0; g < `NUM_RP_OUT; g++) begin : gOut
			logic ppsAct;
			assign ppsAct = outSel_r[g] != 6'h00 &&
				outSel_r[g] <= 6'(`NUM_PERIPH_OUT);
			// inputs never touch the enable: remapped inputs own nothing
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					pinOut[g] <= 1'b0;
					pinOe[g] <= 1'b0;
				end else if (usbOwn[g]) begin
					pinOut[g] <= usbOutLvl[g];
					pinOe[g] <= usbOe[g];
				end else if (ppsAct) begin
					pinOut[g] <= periphOut[outSel_r[g]];
					pinOe[g] <= 1'b1;
				end else begin
					pinOut[g] <= portOut[g];
					pinOe[g] <= ~portDirIn[g];
				end
			end
		end
	endgenerate

	// port read path sees zero on analog pins
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			portInLvl <= '0;
		else
			portInLvl <= gatedLvl;
	end

	assign lvlWords = {4'h0, gatedLvl};

	// read mux; anything unmapped and unimplemented bits read zero, except notice bits 84-95, which read back as written
	always_comb begin
		rdNxt = '0;
		if (regAddr == `OFS_ANA_E)
			rdNxt = anaE_r;
		else if (regAddr == `OFS_ANA_F)
			rdNxt = anaF_r;
		else if (regAddr == `OFS_ANA_G)
			rdNxt = anaG_r;
		else if (hit(regAddr, `OFS_CN_EN, 8'(`CN_WORDS)))
			rdNxt = cnEn_r[cnIdx];
		else if (hit(regAddr, `OFS_CN_PU, 8'(`CN_WORDS)))
			rdNxt = cnPu_r[cnIdx];
		else if (hit(regAddr, `OFS_CN_PD, 8'(`CN_WORDS)))
			rdNxt = cnPd_r[cnIdx];
		else if (regAddr == `OFS_CN_STAT)
			rdNxt[`CN_FLAG_BIT] = cnFlag_r;
		else if (regAddr == `OFS_LOCK)
			rdNxt[`LOCK_BIT] = locked_r;
		else if (hit(regAddr, `OFS_LEVEL, 8'(`LEVEL_WORDS)))
			rdNxt = lvlWords[16*regAddr[1:0] +: 16];
		else if (hit(regAddr, `OFS_IN_MAP, 8'(`IN_MAP_WORDS)))
			rdNxt = {2'b00, inSel_r[{inIdx, 1'b1}], 2'b00,
				inSel_r[{inIdx, 1'b0}]};
		else if (hit(regAddr, `OFS_OUT_MAP, 8'(`OUT_MAP_WORDS)))
			rdNxt = {2'b00, outSel_r[{outIdx, 1'b1}], 2'b00,
				outSel_r[{outIdx, 1'b0}]};
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			regRdData <= '0;
		else if (regRd)
			regRdData <= rdNxt;
		else
			regRdData <= '0;
	end
endmodule
`default_nettype wire

// >>> bench/io_pin_function_properties.sv
`include "io_pin_function_regs.svh"
`default_nettype none
module io_pin_function_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire io_pin_function_pkg::addr_t regAddr,
	input wire io_pin_function_pkg::word_t regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire io_pin_function_pkg::word_t regRdData,
	// pins
	input wire logic cnIrq,
	input wire logic [`NUM_CN-1:0] pullUpEn,
	input wire logic [`NUM_CN-1:0] pullDnEn,
	input wire logic [`NUM_RP-1:0] pinIn,
	input wire logic [`NUM_RP_OUT-1:0] pinOut,
	input wire logic [`NUM_RP_OUT-1:0] pinOe,
	input wire logic [`NUM_RP-1:0] portInLvl,
	input wire logic [`NUM_RP_OUT-1:0] usbOwn,
	input wire logic [`NUM_RP_OUT-1:0] usbOutLvl,
	input wire logic [`NUM_RP_OUT-1:0] usbOe
);
	logic ana9_r;
	wire clrIrq = regWr && regAddr == `OFS_CN_STAT && regWrData[0];
	// shadow of the one analog bit whose pad we watch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) ana9_r <= 1'b1;
		else if (regWr && regAddr == `OFS_ANA_E) ana9_r <= regWrData[9];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence digital_held;
		!ana9_r [*4];
	endsequence
	a_read_idle: assert property (
		!$past(regRd) |-> regRdData == 16'h0000) else $error("stray read data");
	a_ana_bits: assert property (
		regRd && regAddr == `OFS_ANA_E |=> (regRdData & ~`ANA_E_MASK) == 16'h0000)
		else $error("unimplemented bits read nonzero");
	a_ana_block: assert property (
		ana9_r |=> !portInLvl[`RP_OF_E9]) else $error("analog pad level leaked");
	a_dig_follow: assert property (
		digital_held |-> portInLvl[`RP_OF_E9] == $past(pinIn[`RP_OF_E9], 3))
		else $error("digital pad level not followed");
	a_usb_level: assert property (
		((pinOut ^ $past(usbOutLvl)) & $past(usbOwn) & $past(usbOwn, 2)) == '0)
		else $error("usb level lost on owned pin");
	a_usb_oe: assert property (
		((pinOe ^ $past(usbOe)) & $past(usbOwn) & $past(usbOwn, 2)) == '0)
		else $error("usb enable lost on owned pin");
	a_irq_hold: assert property (
		cnIrq && !clrIrq |=> cnIrq) else $error("change flag dropped");
	a_pullup_wr: assert property (
		regWr && regAddr == `OFS_CN_PU |=> pullUpEn[15:0] == $past(regWrData))
		else $error("pull-up enables not written");
	a_pulldn_wr: assert property (
		regWr && regAddr == `OFS_CN_PD |=> pullDnEn[15:0] == $past(regWrData))
		else $error("pull-down enables not written");
endmodule
bind io_pin_function_control io_pin_function_checker io_pin_function_checker_inst (
	.clk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .cnIrq,
	.pullUpEn, .pullDnEn, .pinIn, .pinOut, .pinOe, .portInLvl, .usbOwn,
	.usbOutLvl, .usbOe);
`default_nettype wire

// >>> bench/pad_world.sv
`default_nettype none
module pad_world (
	// design side
	input wire logic [31:0] pinOut,
	input wire logic [31:0] pinOe,
	// outside drivers
	input wire logic [43:0] extLvl,
	// resolved pads
	output logic [43:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// a driven pad reads back the design's own level
	assign pinIn = {extLvl[43:32], (pinOe & pinOut) | (~pinOe & extLvl[31:0])};
endmodule
`default_nettype wire

// >>> bench/test_io_pin_function_control.sv
`include "io_pin_function_regs.svh"
`default_nettype none
module test_io_pin_function_control;
	timeunit 1ns;
	timeprecision 1ps;
	import io_pin_function_pkg::*;
	logic clk = 0, rstn = 0, regWr = 0, regRd = 0, cnIrq, cnWake;
	addr_t regAddr = '0;
	word_t regWrData = '0, regRdData;
	logic [83:0] cnIn = '0, pullUpEn, pullDnEn;
	logic [43:0] pinIn, portInLvl, extLvl = '0;
	logic [31:0] pinOut, pinOe, portOut = '0, usbOwn = '0, usbOutLvl = '0;
	logic [31:0] usbOe = '0, portDirIn = 32'hFFFFFFFC;
	logic [30:1] periphOut = '0;
	logic [35:0] periphIn;
	int badCount = 0, nChecks = 0, cycles = 0;
	io_pin_function_control io_pin_function_control_inst (.clk, .rstn,
		.regAddr, .regWrData, .regWr, .regRd, .regRdData, .cnIn, .pullUpEn,
		.pullDnEn, .cnIrq, .cnWake, .pinIn, .pinOut, .pinOe, .portInLvl,
		.portOut, .portDirIn, .usbOwn, .usbOutLvl, .usbOe, .periphOut,
		.periphIn);
	pad_world pad_world_inst (.pinOut, .pinOe, .extLvl, .pinIn);
	always #2.5 clk = ~clk;
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			badCount++;
			report_and_stop();
		end
	end
	task automatic chk(input string nm, input logic [43:0] e, g);
		nChecks++;
		if (g !== e) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input addr_t a, input word_t d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input addr_t a, input word_t e);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(nm, e, regRdData);
	endtask
	// covers the 3-4 edge pin latency with margin
	task automatic settle;
		repeat (5) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rdchk("anaE", `OFS_ANA_E, `ANA_E_RST);
		rdchk("anaF", `OFS_ANA_F, `ANA_F_RST);
		rdchk("anaG", `OFS_ANA_G, `ANA_G_RST);
		wr(`OFS_ANA_G, 16'hFFFF);
		rdchk("anaGmask", `OFS_ANA_G, 16'h03C0);
		rdchk("unmapped", 8'h7F, 16'h0000);
		extLvl[24] <= 1'b1;
		extLvl[43] <= 1'b1;
		extLvl[2] <= 1'b1;
		wr(`OFS_IN_MAP, 16'h2B18);
		settle();
		chk("lvlAnalog", 0, portInLvl[24]);
		chk("inAnalog", 0, periphIn[0]);
		chk("inOnlyPin", 1, periphIn[1]);
		chk("unassigned", 0, periphIn[2]);
		wr(`OFS_ANA_E, 16'h0000);
		settle();
		chk("lvlDigital", 1, portInLvl[24]);
		chk("inDigital", 1, periphIn[0]);
		rdchk("lvlMid", `OFS_LEVEL + 8'h01, 16'h0100);
		rdchk("lvlHigh", `OFS_LEVEL + 8'h02, 16'h0800);
		periphOut[3] <= 1'b1;
		wr(`OFS_OUT_MAP, 16'h0003);
		wr(`OFS_IN_MAP + 8'h01, 16'h0002);
		settle();
		chk("remapOut", 3, {pinOe[0], pinOut[0]});
		chk("nullSel", 2, {pinOe[1], pinOut[1]});
		chk("inNoOwn", 0, pinOe[2]);
		chk("inSameTime", 1, periphIn[2]);
		usbOwn[0] <= 1'b1;
		usbOe[0] <= 1'b1;
		settle();
		chk("usbWins", 2, {pinOe[0], pinOut[0]});
		wr(`OFS_LOCK, 16'h0001);
		wr(`OFS_OUT_MAP, 16'h0000);
		rdchk("locked", `OFS_OUT_MAP, 16'h0003);
		wr(`OFS_KEY, `UNLOCK_KEY1);
		wr(`OFS_KEY, `UNLOCK_KEY2);
		wr(`OFS_LOCK, 16'h0000);
		wr(`OFS_OUT_MAP, 16'h0005);
		rdchk("unlocked", `OFS_OUT_MAP, 16'h0005);
		// a wrong second key must drop the sequence and keep the lock
		wr(`OFS_LOCK, 16'h0001);
		wr(`OFS_KEY, `UNLOCK_KEY1);
		wr(`OFS_KEY, `UNLOCK_KEY1);
		wr(`OFS_KEY, `UNLOCK_KEY2);
		wr(`OFS_LOCK, 16'h0000);
		rdchk("abortKeys", `OFS_LOCK, 16'h0001);
		wr(`OFS_CN_EN, 16'h0008);
		// pull-ups set on the notice pins beside the driven outputs
		wr(`OFS_CN_PU, 16'h00A4);
		wr(`OFS_CN_PD, 16'h5A00);
		cnIn[4] <= 1'b1;
		// usb notice pins stay disabled: no transceiver-disable control here
		cnIn[83:82] <= 2'b11;
		settle();
		chk("pullUp", 16'h00A4, pullUpEn[15:0]);
		chk("pullDn", 16'h5A00, pullDnEn[15:0]);
		chk("maskedPin", 0, cnIrq);
		cnIn[3] <= 1'b1;
		#0.5 chk("wake", 1, cnWake);
		settle();
		chk("irqSet", 1, cnIrq);
		wr(`OFS_CN_STAT, 16'h0001);
		settle();
		chk("irqClear", 0, cnIrq);
		report_and_stop();
	end
endmodule
`default_nettype wire
